// ==== bench/dtr_chk.sv ====
// Concurrent checks on the ports of the down timer and status block.
`timescale 1ns/10ps
module dtr_chk (
    // Clock and resets
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       watchdog_reset,
    // Instruction inputs
    input wire logic       timer_set_immediate_instr,
    input wire logic       timer_set_reg_instr,
    input wire logic [7:0] operand,
    input wire logic [3:0] accumulator,
    input wire logic [3:0] reg_operand,
    input wire logic       request_clear_instr,
    // Observed outputs
    input wire logic [3:0] arith_status,
    input wire logic [3:0] start_status,
    input wire logic [3:0] release_source_status,
    input wire logic [5:0] down_timer,
    input wire logic       timer_running,
    input wire logic       timer_irq,
    input wire logic       timer_release_request
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic       no_load;
    logic [5:0] imm_count;
    logic [5:0] reg_count;
    assign no_load   = !timer_set_immediate_instr && !timer_set_reg_instr && !watchdog_reset;
    assign imm_count = operand[5:0];
    assign reg_count = {accumulator[1:0], reg_operand};
    // =====================================================================
    // Sequences
    sequence s_imm_load;
        timer_set_immediate_instr && !timer_set_reg_instr && !watchdog_reset;
    endsequence
    sequence s_wrap;
        no_load && timer_running && down_timer == 6'h00 ##1 down_timer == 6'h3f;
    endsequence
    // =====================================================================
    // Counter
    a_imm_load_value: assert property (s_imm_load |=>
        down_timer == $past(imm_count) && timer_running) else $error("immediate load wrong");
    a_reg_load_value: assert property (timer_set_reg_instr && !watchdog_reset |=>
        down_timer == $past(reg_count) && timer_running) else $error("register load wrong");
    a_count_steps: assert property (no_load |=> down_timer == $past(down_timer) ||
        down_timer == $past(down_timer) - 6'h01) else $error("counter jumped");
    // =====================================================================
    // Request and interrupt
    a_wrap_sets_req: assert property (s_wrap |-> timer_release_request)
        else $error("underflow left request clear");
    a_req_holds: assert property (timer_release_request && !watchdog_reset &&
        !(request_clear_instr && operand[1]) |=> timer_release_request)
        else $error("request dropped without clear");
    a_req_cause: assert property ($rose(timer_release_request) |->
        down_timer == 6'h3f) else $error("request rose without underflow");
    a_irq_needs_req: assert property (!timer_release_request |=> !timer_irq)
        else $error("interrupt without request");
    // =====================================================================
    // Status registers
    a_zero_tracks_acc: assert property ($stable(accumulator) [*3] |->
        arith_status[2] == (accumulator == 4'h0)) else $error("zero flag wrong");
    a_unused_zero: assert property (arith_status[1:0] == 2'h0 && !start_status[3])
        else $error("unused status bit set");
    a_other_is_or: assert property ($stable(release_source_status) [*2] |->
        start_status[2] == (release_source_status[0] || release_source_status[1] ||
        release_source_status[3])) else $error("other source flag wrong");
endmodule

bind dtr_top dtr_chk i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .watchdog_reset(watchdog_reset),
    .timer_set_immediate_instr(timer_set_immediate_instr),
    .timer_set_reg_instr(timer_set_reg_instr), .operand(operand),
    .accumulator(accumulator), .reg_operand(reg_operand),
    .request_clear_instr(request_clear_instr), .arith_status(arith_status),
    .start_status(start_status), .release_source_status(release_source_status),
    .down_timer(down_timer), .timer_running(timer_running), .timer_irq(timer_irq),
    .timer_release_request(timer_release_request)
);

// ==== bench/testbench.sv ====
// Self-checking testbench for the down timer, halt release and status block.
`timescale 1ns/10ps
module testbench;
    localparam int TSI = 0, TSR = 1, FSET = 2, FRST = 3, CLR = 4;
    localparam int REL = 5, IRQ = 6, PSEL = 7, AWR = 8, HALT = 9;
    localparam int LIMIT = 90000;
    localparam logic [1:0] SELS [3] = '{2'h1, 2'h0, 2'h2};
    localparam int PERIODS [3] = '{8, 512, 32768};
    logic       clk_sys, rst_n, watchdog_reset, osc_tick, ext_in, wake_port, extint_pulse;
    logic [9:0] strb;
    logic [7:0] operand;
    logic [3:0] accumulator, reg_operand, mem_data;
    logic [3:0] arith_status, start_status, release_source_status;
    logic [5:0] down_timer;
    logic       timer_running, timer_irq, halted, timer_release_request;
    int         bad_count, tests_run, cycles, n;

    dtr_top i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .watchdog_reset(watchdog_reset),
        .osc_tick(osc_tick), .external_frequency_input(ext_in),
        .timer_set_immediate_instr(strb[TSI]), .timer_set_reg_instr(strb[TSR]),
        .operand(operand), .accumulator(accumulator), .reg_operand(reg_operand),
        .flag_set_instr(strb[FSET]), .flag_reset_instr(strb[FRST]),
        .request_clear_instr(strb[CLR]), .release_enable_instr(strb[REL]),
        .irq_enable_instr(strb[IRQ]), .port_change_select_instr(strb[PSEL]),
        .arith_status_write_instr(strb[AWR]), .mem_data(mem_data),
        .carry_update(1'b0), .carry_in(1'b0), .halt_instr(strb[HALT]),
        .wake_port(wake_port), .extint_edge(extint_pulse), .arith_status(arith_status),
        .start_status(start_status), .release_source_status(release_source_status),
        .down_timer(down_timer), .timer_running(timer_running), .timer_irq(timer_irq),
        .halted(halted), .timer_release_request(timer_release_request)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // =====================================================================
    // Tasks
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Status outputs lag one cycle, so two cycles pass before anything is read.
    task automatic instr(input int which, input logic [7:0] op);
        operand = op;
        strb[which] = 1'b1;
        step(1);
        strb = '0;
        step(2);
    endtask
    // Slow edges hold each level for three cycles, so the edge detector sees every rise.
    task automatic ext_edges(input int k);
        repeat (k) begin
            ext_in = 1'b1;
            step(3);
            ext_in = 1'b0;
            step(3);
        end
    endtask
    task automatic measure(output int k);
        logic [5:0] prev;
        prev = down_timer;
        k = 0;
        while (down_timer === prev && k < 40000) begin
            step(1);
            k++;
        end
    endtask
    task automatic end_sim;
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            end_sim();
        end
    end

    // =====================================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        watchdog_reset = 1'b0;
        osc_tick = 1'b0;
        ext_in = 1'b0;
        wake_port = 1'b0;
        extint_pulse = 1'b0;
        strb = '0;
        operand = 8'h00;
        accumulator = 4'h5;
        reg_operand = 4'h0;
        mem_data = 4'hf;
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        step(16);
        rst_n = 1'b1;
        step(2);
        check({down_timer, timer_running, timer_irq, halted, timer_release_request}, 16'h0);
        check({arith_status, start_status, release_source_status}, 16'h0);
        instr(AWR, 8'h00);
        check({arith_status, start_status}, 16'h80);
        accumulator = 4'h0;
        step(3);
        check(arith_status, 16'hc);
        mem_data = 4'h0;
        instr(AWR, 8'h00);
        check(arith_status, 16'h4);
        accumulator = 4'hc;
        reg_operand = 4'h2;
        instr(FSET, 8'h02);
        check(start_status, 16'h1);
        instr(FRST, 8'h02);
        check(start_status, 16'h0);
        instr(TSR, 8'h00);
        check({timer_running, down_timer}, 16'h42);
        watchdog_reset = 1'b1;
        step(1);
        watchdog_reset = 1'b0;
        step(1);
        check({timer_running, down_timer}, 16'h0);
        accumulator = 4'h5;
        instr(TSI, 8'hc3);
        check(down_timer, 16'h3);
        ext_edges(3);
        check({timer_release_request, down_timer}, 16'h0);
        ext_edges(1);
        check({timer_release_request, timer_running, down_timer}, 16'hbf);
        ext_edges(1);
        check(down_timer, 16'h3f);
        instr(IRQ, 8'h02);
        check(timer_irq, 16'h1);
        instr(IRQ, 8'h00);
        check(timer_irq, 16'h0);
        instr(HALT, 8'h00);
        check(halted, 16'h1);
        instr(REL, 8'h02);
        check({halted, release_source_status, start_status}, 16'h024);
        instr(HALT, 8'h00);
        check(halted, 16'h0);
        instr(REL, 8'h00);
        check({release_source_status, start_status}, 16'h0);
        extint_pulse = 1'b1;
        step(1);
        extint_pulse = 1'b0;
        instr(REL, 8'h04);
        check({release_source_status, start_status}, 16'h14);
        instr(CLR, 8'h04);
        check({release_source_status, start_status}, 16'h0);
        instr(REL, 8'h02);
        instr(FRST, 8'h80);
        instr(CLR, 8'h0c);
        check(timer_release_request, 16'h1);
        instr(CLR, 8'h02);
        check({timer_release_request, release_source_status, start_status}, 16'h0);
        instr(HALT, 8'h00);
        instr(PSEL, 8'h02);
        wake_port = 1'b1;
        step(1);
        wake_port = 1'b0;
        step(2);
        check({halted, start_status}, 16'h02);
        instr(PSEL, 8'h00);
        check(start_status, 16'h0);
        instr(TSI, 8'hc1);
        instr(FSET, 8'h80);
        ext_edges(2);
        check({timer_release_request, timer_running, down_timer}, 16'hff);
        ext_edges(1);
        check(down_timer, 16'h3e);
        instr(FRST, 8'h80);
        ext_edges(1);
        check({timer_running, down_timer}, 16'h3e);
        instr(TSI, 8'hc1);
        instr(FSET, 8'h80);
        ext_edges(2);
        instr(TSI, 8'hc1);
        instr(FRST, 8'h80);
        ext_edges(1);
        check({timer_running, down_timer}, 16'h40);
        ext_edges(1);
        check({timer_running, down_timer}, 16'h3f);
        osc_tick = 1'b1;
        for (int s = 0; s < 3; s++) begin
            instr(TSI, {SELS[s], 6'h03});
            measure(n);
            measure(n);
            check(16'(n), 16'(PERIODS[s]));
        end
        // The fifteenth stage has just rolled over, so its level is low here.
        instr(REL, 8'h08);
        check({release_source_status, start_status}, 16'h84);
        end_sim();
    end
endmodule

// ==== rtl/dtr_edge_sync.sv ====
// Rising edge detector for the external frequency input.
`timescale 1ns/10ps
module dtr_edge_sync (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Input level and edge pulse
    input  wire logic level_in,
    output logic      rise_tick
);
    logic prev;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= level_in;
        end
    end

    assign rise_tick = level_in && !prev;
endmodule

// ==== rtl/dtr_pkg.sv ====
// Constants shared by the down timer, halt release and status block.
package dtr_pkg;
    // =====================================================================
    // Counter layout
    localparam int          TIMER_WIDTH   = 6;
    localparam logic [5:0]  TIMER_WRAP    = 6'h3f;
    localparam int          SEL_MSB       = 7;
    localparam int          SEL_LSB       = 6;
    localparam int          COUNT_MSB     = 5;
    // =====================================================================
    // Clock select codes
    localparam logic [1:0]  SEL_STAGE9    = 2'h0;
    localparam logic [1:0]  SEL_STAGE3    = 2'h1;
    localparam logic [1:0]  SEL_STAGE15   = 2'h2;
    localparam logic [1:0]  SEL_EXTERNAL  = 2'h3;
    localparam logic [1:0]  SEL_RESET     = SEL_STAGE3;
    // =====================================================================
    // Prescaler tap periods in prescaler input periods
    localparam int          TAP3_PERIOD   = 8;
    localparam int          TAP9_PERIOD   = 512;
    localparam int          TAP15_PERIOD  = 32768;
    localparam int          PRESCALE_BITS = 15;
    // =====================================================================
    // Flag instruction operands
    localparam logic [7:0]  FLAG_RELOAD   = 8'h80;
    localparam logic [7:0]  FLAG_BACKUP   = 8'h02;
    localparam logic [7:0]  FLAG_CARRY    = 8'h01;
    // =====================================================================
    // Status bit positions
    localparam int          ARITH_CARRY   = 3;
    localparam int          ARITH_ZERO    = 2;
    localparam int          START_BACKUP  = 0;
    localparam int          START_PORT    = 1;
    localparam int          START_OTHER   = 2;
    localparam int          REL_EXTINT    = 0;
    localparam int          REL_TIMER     = 1;
    localparam int          REL_STAGE15   = 2;
    localparam int          REL_PRESCALER = 3;
    // Release enable / request operand bit positions.
    localparam int          SRC_TIMER     = 1;
    localparam int          SRC_EXTINT    = 2;
    localparam int          SRC_PRESCALER = 3;
endpackage

// ==== rtl/dtr_prescaler.sv ====
// Prescaler divider producing one-cycle tap enables.
`timescale 1ns/10ps
module dtr_prescaler #(
    parameter int WIDTH = dtr_pkg::PRESCALE_BITS
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Prescaler input enable
    input  wire logic             osc_tick,
    // Tap outputs
    output logic                  tap3_tick,
    output logic                  tap9_tick,
    output logic                  tap15_tick,
    output logic                  stage15_level,
    output logic                  overflow_tick
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (osc_tick) begin
            count <= next_count;
        end
    end

    // Each tap fires when its low bits roll over, giving periods 8, 512, 32768.
    assign tap3_tick     = osc_tick && (count[2:0] == 3'h7);
    assign tap9_tick     = osc_tick && (count[8:0] == 9'h1ff);
    assign tap15_tick    = osc_tick && (&count);
    assign overflow_tick = tap15_tick;
    assign stage15_level = count[WIDTH-1];
endmodule

// ==== rtl/dtr_top.sv ====
// Down timer, halt release flags and status registers.
`timescale 1ns/10ps
module dtr_top (
    // Clock and resets
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       watchdog_reset,
    // Clock sources
    input  wire logic       osc_tick,
    input  wire logic       external_frequency_input,
    // Instruction strobes
    input  wire logic       timer_set_immediate_instr,
    input  wire logic       timer_set_reg_instr,
    input  wire logic [7:0] operand,
    input  wire logic [3:0] accumulator,
    input  wire logic [3:0] reg_operand,
    input  wire logic       flag_set_instr,
    input  wire logic       flag_reset_instr,
    input  wire logic       request_clear_instr,
    input  wire logic       release_enable_instr,
    input  wire logic       irq_enable_instr,
    input  wire logic       port_change_select_instr,
    input  wire logic       arith_status_write_instr,
    input  wire logic [3:0] mem_data,
    input  wire logic       carry_update,
    input  wire logic       carry_in,
    input  wire logic       halt_instr,
    // Event inputs
    input  wire logic       wake_port,
    input  wire logic       extint_edge,
    // Status reads
    output logic [3:0]      arith_status,
    output logic [3:0]      start_status,
    output logic [3:0]      release_source_status,
    // Timer and halt outputs
    output logic [5:0]      down_timer,
    output logic            timer_running,
    output logic            timer_irq,
    output logic            halted,
    output logic            timer_release_request
);
    logic [1:0] clk_select;
    logic       reload_mode;
    logic       reloaded;
    logic       timer_irq_enable;
    logic       timer_release_enable;
    logic       extint_release_request;
    logic       extint_release_enable;
    logic       prescaler_release_request;
    logic       prescaler_release_enable;
    logic       port_change_enable;
    logic       port_change_start_flag;
    logic       backup_mode_flag;
    logic       carry_flag;
    logic       tap3_tick;
    logic       tap9_tick;
    logic       tap15_tick;
    logic       stage15_level;
    logic       overflow_tick;
    logic       ext_tick;
    logic       count_tick;
    logic       underflow;
    logic       timer_load;
    logic [7:0] load_value;
    logic       timer_start_flag;
    logic       extint_start_flag;
    logic       prescaler_start_flag;
    logic       other_source_start_flag;
    logic       any_start;

    function automatic logic flag_hit(input logic strobe, input logic [7:0] op,
                                      input logic [7:0] code);
        flag_hit = strobe && (op == code);
    endfunction

    // =====================================================================
    // Clock sources
    dtr_prescaler #(
        .WIDTH(dtr_pkg::PRESCALE_BITS)
    ) u_prescaler (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .osc_tick      (osc_tick),
        .tap3_tick     (tap3_tick),
        .tap9_tick     (tap9_tick),
        .tap15_tick    (tap15_tick),
        .stage15_level (stage15_level),
        .overflow_tick (overflow_tick)
    );

    dtr_edge_sync u_ext (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .level_in  (external_frequency_input),
        .rise_tick (ext_tick)
    );

    always_comb begin
        case (clk_select)
            dtr_pkg::SEL_STAGE9:  count_tick = tap9_tick;
            dtr_pkg::SEL_STAGE3:  count_tick = tap3_tick;
            dtr_pkg::SEL_STAGE15: count_tick = tap15_tick;
            default:              count_tick = ext_tick;
        endcase
    end

    // =====================================================================
    // Timer load
    assign timer_load = timer_set_immediate_instr || timer_set_reg_instr;
    assign load_value = timer_set_reg_instr ? {accumulator, reg_operand} : operand;
    assign underflow  = timer_running && count_tick && (down_timer == '0);

    // Watchdog reset is not tied to rst_n, so the selection survives it.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clk_select <= dtr_pkg::SEL_RESET;
        end else if (timer_load) begin
            clk_select <= load_value[dtr_pkg::SEL_MSB:dtr_pkg::SEL_LSB];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            down_timer <= '0;
        end else if (watchdog_reset) begin
            down_timer <= '0;
        end else if (timer_load) begin
            down_timer <= load_value[dtr_pkg::COUNT_MSB:0];
        end else if (timer_running && count_tick) begin
            down_timer <= down_timer - 6'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reload_mode <= 1'b0;
        end else if (watchdog_reset) begin
            reload_mode <= 1'b0;
        end else if (flag_hit(flag_set_instr, operand, dtr_pkg::FLAG_RELOAD)) begin
            reload_mode <= 1'b1;
        end else if (flag_hit(flag_reset_instr, operand, dtr_pkg::FLAG_RELOAD)) begin
            reload_mode <= 1'b0;
        end
    end

    // Tracks whether a timer-set followed the latest underflow.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reloaded <= 1'b0;
        end else if (timer_load) begin
            reloaded <= 1'b1;
        end else if (underflow) begin
            reloaded <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_running <= 1'b0;
        end else if (watchdog_reset) begin
            timer_running <= 1'b0;
        end else if (timer_load) begin
            timer_running <= 1'b1;
        end else if (flag_hit(flag_set_instr, operand, dtr_pkg::FLAG_RELOAD)) begin
            timer_running <= 1'b1;
        end else if (flag_hit(flag_reset_instr, operand, dtr_pkg::FLAG_RELOAD)
                     && !reloaded) begin
            timer_running <= 1'b0;
        end else if (underflow && !reload_mode) begin
            timer_running <= 1'b0;
        end
    end

    // =====================================================================
    // Release requests, enables and start flags
    // Set wins over the clear so an underflow in the clear cycle is kept.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_release_request     <= 1'b0;
            extint_release_request    <= 1'b0;
            prescaler_release_request <= 1'b0;
        end else begin
            if (underflow) begin
                timer_release_request <= 1'b1;
            end else if (request_clear_instr && operand[dtr_pkg::SRC_TIMER]) begin
                timer_release_request <= 1'b0;
            end
            if (extint_edge) begin
                extint_release_request <= 1'b1;
            end else if (request_clear_instr && operand[dtr_pkg::SRC_EXTINT]) begin
                extint_release_request <= 1'b0;
            end
            if (overflow_tick) begin
                prescaler_release_request <= 1'b1;
            end else if (request_clear_instr && operand[dtr_pkg::SRC_PRESCALER]) begin
                prescaler_release_request <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_release_enable     <= 1'b0;
            extint_release_enable    <= 1'b0;
            prescaler_release_enable <= 1'b0;
            timer_irq_enable         <= 1'b0;
        end else begin
            if (release_enable_instr) begin
                timer_release_enable     <= operand[dtr_pkg::SRC_TIMER];
                extint_release_enable    <= operand[dtr_pkg::SRC_EXTINT];
                prescaler_release_enable <= operand[dtr_pkg::SRC_PRESCALER];
            end
            if (irq_enable_instr) begin
                timer_irq_enable <= operand[dtr_pkg::SRC_TIMER];
            end
        end
    end

    // The start flag follows the interrupt-enable clear condition only for the timer.
    assign timer_start_flag = timer_release_request && timer_release_enable
                              && !timer_irq_enable;
    assign extint_start_flag    = extint_release_request && extint_release_enable;
    assign prescaler_start_flag = prescaler_release_request
                                  && prescaler_release_enable;
    assign other_source_start_flag = extint_start_flag || timer_start_flag
                                     || prescaler_start_flag;
    assign any_start = other_source_start_flag || port_change_start_flag;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port_change_enable     <= 1'b0;
            port_change_start_flag <= 1'b0;
        end else begin
            if (port_change_select_instr) begin
                port_change_enable <= operand[dtr_pkg::START_PORT];
            end
            if (wake_port && port_change_enable && halted) begin
                port_change_start_flag <= 1'b1;
            end else if (port_change_select_instr) begin
                port_change_start_flag <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Halt and interrupt
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            halted <= 1'b0;
        end else if (halted && any_start) begin
            halted <= 1'b0;
        end else if (halt_instr && !any_start) begin
            halted <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= timer_release_request && timer_irq_enable;
        end
    end

    // =====================================================================
    // Status flags and registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            carry_flag <= 1'b0;
        end else if (arith_status_write_instr) begin
            carry_flag <= mem_data[dtr_pkg::ARITH_CARRY];
        end else if (flag_hit(flag_set_instr, operand, dtr_pkg::FLAG_CARRY)) begin
            carry_flag <= 1'b1;
        end else if (flag_hit(flag_reset_instr, operand, dtr_pkg::FLAG_CARRY)) begin
            carry_flag <= 1'b0;
        end else if (carry_update) begin
            carry_flag <= carry_in;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            backup_mode_flag <= 1'b0;
        end else if (flag_hit(flag_set_instr, operand, dtr_pkg::FLAG_BACKUP)) begin
            backup_mode_flag <= 1'b1;
        end else if (flag_hit(flag_reset_instr, operand, dtr_pkg::FLAG_BACKUP)) begin
            backup_mode_flag <= 1'b0;
        end
    end

    // Registered copies keep every output straight from a flip-flop.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arith_status          <= 4'h0;
            start_status          <= 4'h0;
            release_source_status <= 4'h0;
        end else begin
            arith_status <= {carry_flag, (accumulator == 4'h0), 2'h0};
            start_status <= {1'b0, other_source_start_flag, port_change_start_flag,
                             backup_mode_flag};
            release_source_status <= {prescaler_start_flag, stage15_level,
                                      timer_start_flag, extint_start_flag};
        end
    end
endmodule
